// file: sld_driver.sv
// Static 40-segment display driver: serial shift, load, divider, blink, commons.
// Assumes all pin inputs are asynchronous to clk and at least 0.4 us wide.
//
// Contract
// - A load strobe copies the whole shift register into the display register.
// - Last stage of the 40-bit shift register drives the serial data output.
// - Low group enable gates segments 1 to 16 together.
// - High group enable gates segments 17 to 40 together.
// - Every enable input is active low.
// - Each common output has its own independent enable.
// - Internal oscillator runs only while enabled, on its own output.
// - Divider gives display taps at 1/16, 1/32, 1/64, 1/128, 1/256.
// - Same divider gives blink taps at 1/8192, 1/16384, 1/32768.
// - Drive timing comes from the separate display clock input.
// - Blink timing comes from the blink clock input, only while blink enabled.
// - Load, shift clock, blink, display clock and group enables pass to next chip.
// - One bit shifts in per shift clock rise; load rise latches the register.
// - Enabled commons carry the inverse of the display clock.
// - Disabled segment outputs are driven low.
`timescale 1ns/100ps
module sld_driver (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_data_in,
  input wire logic serial_shift_clock,
  input wire logic load,
  input wire logic blink_enable_n,
  input wire logic osc_enable_n,
  input wire logic seg_group_low_enable_n,
  input wire logic seg_group_high_enable_n,
  input wire logic common_a_enable_n,
  input wire logic common_b_enable_n,
  input wire logic divider_clock_in,
  input wire logic display_clock_in,
  input wire logic blink_clock_in,
  input wire logic update_hold,
  output logic serial_ready,
  output logic serial_data_out,
  output logic [39:0] segment_out,
  output logic common_out_a,
  output logic common_out_b,
  output logic osc_out,
  output logic [4:0] display_clock_taps,
  output logic [2:0] blink_clock_taps,
  output logic load_thru,
  output logic serial_shift_clock_thru,
  output logic blink_enable_thru_n,
  output logic display_clock_thru,
  output logic seg_group_low_enable_thru_n,
  output logic seg_group_high_enable_thru_n
);

  localparam int N = sld_pkg::SEG_COUNT;
  localparam int P = sld_pkg::PIN_COUNT;

  typedef struct packed {
    logic [P-1:0] sync1;
    logic [P-1:0] sync2;
    logic [P-1:0] prev;
    logic load_pending;
    logic [N-1:0] shift;
    logic [N-1:0] disp;
    logic [N-1:0] seg;
    logic [sld_pkg::DIV_W-1:0] div;
    logic [10:0] osc_cnt;
    logic osc;
    logic blink_off;
    logic com_a;
    logic com_b;
  } sld_state_t;

  sld_state_t st_r;
  sld_state_t st_nxt;

  logic evq_in_valid;
  logic evq_in_ready;
  logic [sld_pkg::EVQ_W-1:0] evq_in_data;
  logic evq_out_valid;
  logic [sld_pkg::EVQ_W-1:0] evq_out_data;
  logic evq_out_ready;

  // Rising edge of a synchronised pin, seen against its value one cycle ago.
  function automatic logic rose(input logic [P-1:0] cur, input logic [P-1:0] old,
                                input int idx);
    rose = cur[idx] && !old[idx];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pad pass-through to the next chained chip. These are plain wires on the
  // die, so they are not resampled; a chained chip synchronises them itself.
  assign load_thru = load;
  assign serial_shift_clock_thru = serial_shift_clock;
  assign blink_enable_thru_n = blink_enable_n;
  assign display_clock_thru = display_clock_in;
  assign seg_group_low_enable_thru_n = seg_group_low_enable_n;
  assign seg_group_high_enable_thru_n = seg_group_high_enable_n;

  //////////////////////////////////////////////////////////////////////////////
  // Shift and load events enter the queue in pin order, so a load always
  // follows the bits shifted before it. A load seen in the same cycle as a
  // shift edge waits one cycle in load_pending rather than being lost.
  logic shift_edge;
  logic load_edge;
  assign shift_edge = rose(st_r.sync2, st_r.prev, sld_pkg::PIN_SCLK);
  assign load_edge = rose(st_r.sync2, st_r.prev, sld_pkg::PIN_LOAD);
  assign evq_in_valid = shift_edge || st_r.load_pending || load_edge;
  assign evq_in_data = shift_edge ? {1'b0, st_r.sync2[sld_pkg::PIN_DIN]} : 2'h2;
  assign evq_out_ready = !update_hold;
  assign serial_ready = evq_in_ready;

  sld_fifo #(
    .WIDTH(sld_pkg::EVQ_W),
    .DEPTH(sld_pkg::EVQ_DEPTH)
  ) u_evq (
    .clk(clk),
    .rst(rst),
    .in_valid(evq_in_valid),
    .in_ready(evq_in_ready),
    .in_data(evq_in_data),
    .out_valid(evq_out_valid),
    .out_ready(evq_out_ready),
    .out_data(evq_out_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole driver.
  logic [N-1:0] group_mask;
  logic fin_edge;
  logic bclk_edge;
  always_comb begin
    st_nxt = st_r;
    // Two-stage synchroniser; stage one feeds stage two only.
    st_nxt.sync1 = {blink_clock_in, display_clock_in, divider_clock_in,
                    common_b_enable_n, common_a_enable_n, seg_group_high_enable_n,
                    seg_group_low_enable_n, osc_enable_n, blink_enable_n, load,
                    serial_shift_clock, serial_data_in};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;

    // A load edge blocked by a shift edge is retried next cycle.
    if (shift_edge && load_edge) begin
      st_nxt.load_pending = 1'b1;
    end else if (!shift_edge) begin
      st_nxt.load_pending = 1'b0;
    end

    // Queue drain: bits shift toward the top so the first bit sent ends on
    // segment 40 and is the bit presented to the next chip.
    if (evq_out_valid && evq_out_ready) begin
      if (evq_out_data[sld_pkg::EVQ_KIND]) begin
        st_nxt.disp = st_r.shift;
      end else begin
        st_nxt.shift = {st_r.shift[N-2:0], evq_out_data[sld_pkg::EVQ_BIT]};
      end
    end

    // Divider chain counts rising edges of the divider clock pin.
    fin_edge = rose(st_r.sync2, st_r.prev, sld_pkg::PIN_FIN);
    if (fin_edge) begin
      st_nxt.div = st_r.div + 1'b1;
    end

    // Oscillator is derived from clk and held low while disabled.
    if (st_r.sync2[sld_pkg::PIN_OEN_N]) begin
      st_nxt.osc = 1'b0;
      st_nxt.osc_cnt = '0;
    end else if (st_r.osc_cnt == sld_pkg::OSC_HALF_CYCLES - 11'h001) begin
      st_nxt.osc = !st_r.osc;
      st_nxt.osc_cnt = '0;
    end else begin
      st_nxt.osc_cnt = st_r.osc_cnt + 11'h001;
    end

    // Blink phase flips on each blink clock rise; it restarts visible when off.
    bclk_edge = rose(st_r.sync2, st_r.prev, sld_pkg::PIN_BCLK);
    if (st_r.sync2[sld_pkg::PIN_BEN_N]) begin
      st_nxt.blink_off = 1'b0;
    end else if (bclk_edge) begin
      st_nxt.blink_off = !st_r.blink_off;
    end

    // Segment groups are gated as a whole and fall to ground when disabled.
    group_mask = '0;
    for (int i = 0; i < N; i++) begin
      if (i < sld_pkg::GROUP_LOW_LAST) begin
        group_mask[i] = !st_r.sync2[sld_pkg::PIN_SEN_LO_N];
      end else begin
        group_mask[i] = !st_r.sync2[sld_pkg::PIN_SEN_HI_N];
      end
    end
    st_nxt.seg = st_r.blink_off ? '0 : (st_r.disp & group_mask);

    // Commons invert the display clock and sit at ground when disabled.
    st_nxt.com_a = !st_r.sync2[sld_pkg::PIN_CEN_A_N] &&
                   !st_r.sync2[sld_pkg::PIN_DISPLAY_CLOCK_IN];
    st_nxt.com_b = !st_r.sync2[sld_pkg::PIN_CEN_B_N] &&
                   !st_r.sync2[sld_pkg::PIN_DISPLAY_CLOCK_IN];
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register. Reset stands in for the power-on clear of both registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.sync1 <= sld_pkg::PIN_RESET;
      st_r.sync2 <= sld_pkg::PIN_RESET;
      st_r.prev <= sld_pkg::PIN_RESET;
      st_r.load_pending <= 1'b0;
      st_r.shift <= sld_pkg::SEG_RESET;
      st_r.disp <= sld_pkg::SEG_RESET;
      st_r.seg <= sld_pkg::SEG_RESET;
      st_r.div <= '0;
      st_r.osc_cnt <= '0;
      st_r.osc <= 1'b0;
      st_r.blink_off <= 1'b0;
      st_r.com_a <= 1'b0;
      st_r.com_b <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all taken from flip-flops.
  assign serial_data_out = st_r.shift[N-1];
  assign segment_out = st_r.seg;
  assign common_out_a = st_r.com_a;
  assign common_out_b = st_r.com_b;
  assign osc_out = st_r.osc;
  assign display_clock_taps = {st_r.div[sld_pkg::TAP_DIV256], st_r.div[sld_pkg::TAP_DIV128],
                               st_r.div[sld_pkg::TAP_DIV64], st_r.div[sld_pkg::TAP_DIV32],
                               st_r.div[sld_pkg::TAP_DIV16]};
  assign blink_clock_taps = {st_r.div[sld_pkg::TAP_DIV32768], st_r.div[sld_pkg::TAP_DIV16384],
                             st_r.div[sld_pkg::TAP_DIV8192]};

endmodule

// file: sld_pkg.sv
// Package for the static segment display driver: pin indices, counts, timing.
// Assumes a single 100 MHz clock domain; all pins except update_hold are sampled into it.
package sld_pkg;

  // Display geometry.
  localparam int SEG_COUNT = 40;
  localparam int GROUP_LOW_LAST = 16;

  // Clock rate and internal oscillator timing.
  localparam longint CLK_HZ = 100000000;
  localparam longint OSC_HZ = 32000;
  localparam logic [10:0] OSC_HALF_CYCLES = 11'(CLK_HZ / (2 * OSC_HZ));

  // Divider chain: width and tap bit positions (tap n divides by 2**(n+1)).
  localparam int DIV_W = 15;
  localparam int TAP_DIV16 = 3;
  localparam int TAP_DIV32 = 4;
  localparam int TAP_DIV64 = 5;
  localparam int TAP_DIV128 = 6;
  localparam int TAP_DIV256 = 7;
  localparam int TAP_DIV8192 = 12;
  localparam int TAP_DIV16384 = 13;
  localparam int TAP_DIV32768 = 14;

  // Index of each sampled pin in the synchroniser vector.
  localparam int PIN_COUNT = 12;
  localparam int PIN_DIN = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_LOAD = 2;
  localparam int PIN_BEN_N = 3;
  localparam int PIN_OEN_N = 4;
  localparam int PIN_SEN_LO_N = 5;
  localparam int PIN_SEN_HI_N = 6;
  localparam int PIN_CEN_A_N = 7;
  localparam int PIN_CEN_B_N = 8;
  localparam int PIN_FIN = 9;
  localparam int PIN_DISPLAY_CLOCK_IN = 10;
  localparam int PIN_BCLK = 11;

  // Event queue between pin sampling and the shift register.
  localparam int EVQ_W = 2;
  localparam int EVQ_DEPTH = 32;
  localparam int EVQ_KIND = 1;
  localparam int EVQ_BIT = 0;

  // Reset values.
  localparam logic [SEG_COUNT-1:0] SEG_RESET = 40'h00_0000_0000;
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 12'hFFF;

endpackage

// file: sld_fifo.sv
// Synchronous FIFO with valid/ready on both sides, flip-flop storage.
// Assumes writer and reader share clk; rst is synchronous, active high.
`timescale 1ns/100ps
module sld_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sld_fifo_state_t;

  sld_fifo_state_t st_r;
  sld_fifo_state_t st_nxt;
  logic do_wr;
  logic do_rd;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (st_r.cnt != FULL_COUNT);
  assign out_valid = (st_r.cnt != '0);
  assign out_data = st_r.mem[st_r.rp];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // Pointers wrap naturally because the depth is a power of two.
  always_comb begin
    st_nxt = st_r;
    if (do_wr) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (do_rd) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    if (do_wr && !do_rd) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (do_rd && !do_wr) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  // Storage is not cleared on reset; only the pointers matter.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.mem <= st_nxt.mem;
      st_r.wp <= '0;
      st_r.rp <= '0;
      st_r.cnt <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// file: sld_driver_properties.sv
// Checker for the segment driver, watching only its top-level ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module sld_driver_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic serial_shift_clock,
  input wire logic blink_enable_n,
  input wire logic osc_enable_n,
  input wire logic seg_group_low_enable_n,
  input wire logic seg_group_high_enable_n,
  input wire logic common_a_enable_n,
  input wire logic common_b_enable_n,
  input wire logic display_clock_in,
  input wire logic blink_clock_in,
  input wire logic update_hold,
  input wire logic [39:0] segment_out,
  input wire logic common_out_a,
  input wire logic common_out_b,
  input wire logic osc_out,
  input wire logic [4:0] display_clock_taps,
  input wire logic load_thru,
  input wire logic serial_shift_clock_thru,
  input wire logic display_clock_thru,
  input wire logic blink_enable_thru_n,
  input wire logic seg_group_low_enable_thru_n,
  input wire logic seg_group_high_enable_thru_n
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  logic [10:0] osc_run_r;
  ////////////////////////////////////////
  // Counts cycles since the oscillator last moved, so a stuck one shows as a large count.
  always_ff @(posedge clk) begin
    if (rst || osc_enable_n || $changed(osc_out)) begin
      osc_run_r <= 11'h000;
    end else if (osc_run_r != 11'h7FF) begin
      osc_run_r <= osc_run_r + 11'h001;
    end
  end
  // Nothing that may move the segments changes for eight cycles.
  sequence quiet_s;
    (!update_hold && $stable({load, seg_group_low_enable_n, seg_group_high_enable_n,
      blink_enable_n}) && (blink_enable_n || $stable(blink_clock_in))) [*8];
  endsequence
  seg_hold_a: assert property (quiet_s |=> $stable(segment_out))
    else $error("segments moved without a load");
  grp_low_off_a: assert property (seg_group_low_enable_n [*5]
    |-> segment_out[15:0] == 16'h0000) else $error("low group not off");
  grp_high_off_a: assert property (seg_group_high_enable_n [*5]
    |-> segment_out[39:16] == 24'h00_0000) else $error("high group not off");
  com_a_follow_a: assert property ((!common_a_enable_n && $stable(display_clock_in)) [*5]
    |-> common_out_a == !display_clock_in) else $error("common a wrong");
  com_b_off_a: assert property (common_b_enable_n [*5] |-> !common_out_b)
    else $error("common b not off");
  osc_off_a: assert property (osc_enable_n [*5] |-> !osc_out)
    else $error("oscillator runs while disabled");
  osc_toggle_a: assert property (osc_run_r < 11'h640)
    else $error("oscillator stuck");
  tap_chain_a: assert property ($changed(display_clock_taps[4:1])
    |-> $fell(display_clock_taps[0])) else $error("divider taps out of order");
  // Every chain pad is checked, so a dropped or swapped wire to the next chip shows up.
  thru_pads_a: assert property ({load_thru, serial_shift_clock_thru, display_clock_thru,
    blink_enable_thru_n, seg_group_low_enable_thru_n, seg_group_high_enable_thru_n}
    == {load, serial_shift_clock, display_clock_in, blink_enable_n, seg_group_low_enable_n,
    seg_group_high_enable_n}) else $error("pass-through differs");
endmodule
bind sld_driver sld_driver_props u_sld_driver_props (.clk, .rst, .load, .serial_shift_clock,
  .blink_enable_n, .osc_enable_n, .seg_group_low_enable_n, .seg_group_high_enable_n,
  .common_a_enable_n, .common_b_enable_n, .display_clock_in, .blink_clock_in, .update_hold,
  .segment_out, .common_out_a, .common_out_b, .osc_out, .display_clock_taps, .load_thru,
  .serial_shift_clock_thru, .display_clock_thru, .blink_enable_thru_n,
  .seg_group_low_enable_thru_n, .seg_group_high_enable_thru_n);

// file: sld_host.sv
// Host model: shifts display frames into the driver and strobes load.
// Assumes send is called from a process that waits on clk rising edges.
`timescale 1ns/100ps
module sld_host (
  input wire logic clk,
  output logic serial_data_in,
  output logic serial_shift_clock,
  output logic load,
  output logic osc_enable_n
);
  // Pins idle low with the oscillator running.
  initial begin
    serial_data_in = 1'h0;
    serial_shift_clock = 1'h0;
    load = 1'h0;
    osc_enable_n = 1'h0;
  end
  // Half is the pin half period in cycles; the oscillator is held off around the transfer.
  task automatic send(input logic [39:0] frame, input int half, input bit do_load);
    osc_enable_n <= 1'h1;
    repeat (half) @(posedge clk);
    for (int i = 39; i >= 0; i--) begin
      serial_data_in <= frame[i];
      repeat (half) @(posedge clk);
      serial_shift_clock <= 1'h1;
      repeat (half) @(posedge clk);
      serial_shift_clock <= 1'h0;
    end
    serial_data_in <= ~frame[0]; // Released line shows the inverse, not a stale bit.
    load <= do_load;
    repeat (half) @(posedge clk);
    load <= 1'h0;
    repeat (half) @(posedge clk);
    osc_enable_n <= 1'h0;
  endtask
endmodule

// file: test_sld_driver.sv
// Self-checking bench for the segment driver against a queue-based model.
// Assumes the host model drives the serial pins and the oscillator enable.
`timescale 1ns/100ps
module test_sld_driver;
  logic clk, rst, blink_enable_n, seg_group_low_enable_n, seg_group_high_enable_n;
  logic common_a_enable_n, common_b_enable_n, divider_clock_in, display_clock_in;
  logic blink_clock_in, update_hold, serial_data_in, serial_shift_clock, load, osc_enable_n;
  logic serial_ready, serial_data_out, common_out_a, common_out_b, osc_out;
  logic [39:0] segment_out, f;
  logic [4:0] display_clock_taps;
  logic [2:0] blink_clock_taps;
  logic [39:0] disp_m = 40'h00_0000_0000;
  bit sq[$];
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 92903;
  int cycles = 0;
  int n;
  sld_driver u_sld_driver (.clk, .rst, .serial_data_in, .serial_shift_clock, .load,
    .blink_enable_n, .osc_enable_n, .seg_group_low_enable_n, .seg_group_high_enable_n,
    .common_a_enable_n, .common_b_enable_n, .divider_clock_in, .display_clock_in,
    .blink_clock_in, .update_hold, .serial_ready, .serial_data_out, .segment_out,
    .common_out_a, .common_out_b, .osc_out, .display_clock_taps, .blink_clock_taps,
    .load_thru(), .serial_shift_clock_thru(), .blink_enable_thru_n(), .display_clock_thru(),
    .seg_group_low_enable_thru_n(), .seg_group_high_enable_thru_n());
  sld_host u_sld_host (.clk, .serial_data_in, .serial_shift_clock, .load, .osc_enable_n);
  ////////////////////////////////////////
  // Free-running clock.
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Cycle limit cuts a hang short and counts as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      $display("wrong value cycles expected below 90000 seen %0d", cycles);
      summarize();
    end
  end
  task automatic summarize;
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Expected segments: blanked in the blink off phase, then gated per group.
  function automatic logic [39:0] seg_exp(input bit off);
    seg_exp = off ? 40'h00_0000_0000 : disp_m;
    if (seg_group_low_enable_n) seg_exp[15:0] = 16'h0000;
    if (seg_group_high_enable_n) seg_exp[39:16] = 24'h00_0000;
  endfunction
  task automatic chk_out;
    chk("segment_out", seg_exp(0), segment_out);
    chk("serial_data_out", {39'h0, sq[0]}, {39'h0, serial_data_out});
  endtask
  // Sends one frame at a random pace and mirrors it in the model.
  task automatic frame(input logic [39:0] v, input bit ld);
    u_sld_host.send(v, 40 + 20 * ($random(seed) & 1), ld);
    for (int i = 39; i >= 0; i--) begin
      sq.push_back(v[i]);
      void'(sq.pop_front());
    end
    if (ld) foreach (sq[i]) disp_m[39 - i] = sq[i];
    repeat (10) @(posedge clk);
    chk_out();
  endtask
  ////////////////////////////////////////
  initial begin
    {rst, blink_enable_n} = 2'h3;
    {seg_group_low_enable_n, seg_group_high_enable_n, common_a_enable_n} = 3'h0;
    {common_b_enable_n, divider_clock_in, display_clock_in, blink_clock_in} = 4'h0;
    update_hold = 1'h0;
    repeat (40) sq.push_back(1'b0);
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    chk_out();
    for (int k = 0; k < 3; k++) frame(40'({$random(seed), $random(seed)}), 1);
    frame(40'({$random(seed), $random(seed)}), 0);
    frame(40'({$random(seed), $random(seed)}), 1);
    // Every combination of group enables, common enables set to the same pattern, commons against the display clock.
    for (int k = 0; k < 4; k++) begin
      {seg_group_low_enable_n, seg_group_high_enable_n} <= 2'(k);
      {common_a_enable_n, common_b_enable_n} <= 2'(k);
      display_clock_in <= k[0] ^ k[1];
      repeat (6) @(posedge clk);
      chk("segment_out", seg_exp(0), segment_out);
      chk("commons", {38'h0, ~(display_clock_in | common_a_enable_n),
        ~(display_clock_in | common_b_enable_n)}, {38'h0, common_out_a, common_out_b});
    end
    {seg_group_low_enable_n, seg_group_high_enable_n} <= 2'h0;
    // Blink: rises flip the phase while enabled, nothing moves while disabled.
    for (int k = 0; k < 6; k++) begin
      blink_enable_n <= (k > 3);
      blink_clock_in <= ~blink_clock_in;
      repeat (40) @(posedge clk);
      chk("segment_out", seg_exp(k < 2), segment_out);
    end
    // Divider taps after a random number of rises.
    n = 1 + ($random(seed) & 255);
    repeat (n) begin
      divider_clock_in <= 1'h1;
      repeat (40) @(posedge clk);
      divider_clock_in <= 1'h0;
      repeat (40) @(posedge clk);
    end
    chk("display_clock_taps", {35'h0, 5'(n >> 3)}, {35'h0, display_clock_taps});
    chk("blink_clock_taps", 40'h0, {37'h0, blink_clock_taps});
    // Stalled queue fills at 32 edges; the rest and the load strobe are refused.
    update_hold <= 1'h1;
    f = 40'({$random(seed), $random(seed)});
    u_sld_host.send(f, 40, 1);
    chk("serial_ready", 40'h0, {39'h0, serial_ready});
    update_hold <= 1'h0;
    for (int i = 39; i >= 8; i--) begin
      sq.push_back(f[i]);
      void'(sq.pop_front());
    end
    repeat (50) @(posedge clk);
    chk_out();
    frame(40'({$random(seed), $random(seed)}), 1);
    summarize();
  end
endmodule
